// File: dpa_debug_port.sv
/*
  Debug port front end: selects at reset release between a four-wire
  test access port and a two-wire debug link sharing the clock and data
  pins, runs the port controller, and drives the trigger pulse output.
  Assumes all pins are asynchronous to core_clk, that the probe clock
  runs no faster than half of core_clk, and that the testbench resolves
  the open-drain and two-way pins from the enables.
*/
// Function
// - Four-pin test port whose controller follows the standard sixteen-state sequence.
// - Test clock high at reset end shuts the test port down.
// - Shut-down port enables two-wire link on test clock and data pins.
// - Two-wire mode uses the test clock pin as its serial clock.
// - Low test reset pin forces the controller to reset, without clock edges.
// - Undriven test clock, reset and mode select pins read as one.
// - Mode select sampled on each rising test clock edge.
// - With port enabled, data input pin is input only, sampled rising.
// - With port disabled, data pin is two-way link data, input after reset.
// - Test data output changes only on falling test clock edges.
// - Valid trigger event gives an active-high pulse on trigger output.
// - Trigger output is released, not driven, when no pulse is out.
`timescale 1ns/10ps

module dpa_debug_port (
  // System clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Test clock pin with drive indication
  input wire logic tck_pin,
  input wire logic tck_pin_drv,
  // Test reset pin, active low, with drive indication
  input wire logic trst_n_pin,
  input wire logic trst_n_pin_drv,
  // Mode select pin with drive indication
  input wire logic tms_pin,
  input wire logic tms_pin_drv,
  // Data input pin, two-way link data in two-wire mode
  input wire logic debug_link_data_io_i,
  output logic debug_link_data_io_o,
  output logic debug_link_data_io_oe,
  // Test data output pin
  output logic tdo_pin,
  output logic tdo_pin_oe,
  // Trigger output pin, open drain
  output logic trigger_pulse_out,
  output logic trigger_pulse_out_oe,
  // Trigger source from debug logic
  input wire logic trigger_event,
  // Two-wire link user side
  input wire logic link_drive_req,
  input wire logic link_drive_bit,
  output logic link_rx_bit,
  output logic link_rx_strobe,
  output logic link_clk_fall,
  // Status
  output logic test_port_enabled,
  output logic mode_valid,
  output logic [3:0] tap_state_out
);

  // ----------------------------------------------------------------
  // Pin resolution and synchronisers
  // ----------------------------------------------------------------
  logic tck_lvl;
  logic trst_lvl;
  logic tms_lvl;
  logic [2:0] tck_sync;
  logic [1:0] trst_sync;
  logic [1:0] tms_sync;
  logic [1:0] tdi_sync;

  // Undriven pins take the pull-up level
  assign tck_lvl = tck_pin_drv ? tck_pin : dpa_pkg::PULLUP_LEVEL;
  assign trst_lvl = trst_n_pin_drv ? trst_n_pin : dpa_pkg::PULLUP_LEVEL;
  assign tms_lvl = tms_pin_drv ? tms_pin : dpa_pkg::PULLUP_LEVEL;

  // Unreset so the level seen at reset release is the real pin level
  always_ff @(posedge core_clk) begin
    tck_sync <= {tck_sync[1:0], tck_lvl};
    trst_sync <= {trst_sync[0], trst_lvl};
    tms_sync <= {tms_sync[0], tms_lvl};
    tdi_sync <= {tdi_sync[0], debug_link_data_io_i};
  end

  logic tck_s;
  logic tck_q;
  logic tck_rise;
  logic tck_fall;
  assign tck_s = tck_sync[1];
  assign tck_q = tck_sync[2];
  assign tck_rise = tck_s & ~tck_q;
  assign tck_fall = ~tck_s & tck_q;

  // ----------------------------------------------------------------
  // Mode choice at reset release
  // ----------------------------------------------------------------
  logic in_reset_q;
  logic port_sel;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      in_reset_q <= 1'b1;
    end else begin
      in_reset_q <= 1'b0;
    end
  end

  // The synchroniser output at the first cycle after release shows the
  // pin two cycles earlier, which is the hold window the probe keeps
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      port_sel <= 1'b0;
      mode_valid <= 1'b0;
    end else if (in_reset_q) begin
      port_sel <= ~tck_s;
      mode_valid <= 1'b1;
    end
  end

  // Status latched with mode_valid so it never moves after the latch
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      test_port_enabled <= 1'b0;
    end else if (in_reset_q) begin
      test_port_enabled <= ~tck_s;
    end
  end

  logic port_on;
  logic link_on;
  assign port_on = port_sel & mode_valid;
  assign link_on = ~port_sel & mode_valid;

  // ----------------------------------------------------------------
  // Test access port controller
  // ----------------------------------------------------------------
  dpa_pkg::dpa_tap_e tap_state;
  dpa_pkg::dpa_tap_e next_tap_state;
  logic tms_s;
  logic tdi_s;
  logic trst_s;
  assign tms_s = tms_sync[1];
  assign tdi_s = tdi_sync[1];
  assign trst_s = trst_sync[1];

  always_comb begin
    next_tap_state = tap_state;
    unique case (tap_state)
      dpa_pkg::TLR: next_tap_state = tms_s ? dpa_pkg::TLR : dpa_pkg::RTI;
      dpa_pkg::RTI: next_tap_state = tms_s ? dpa_pkg::SEL_DR : dpa_pkg::RTI;
      dpa_pkg::SEL_DR: next_tap_state = tms_s ? dpa_pkg::SEL_IR : dpa_pkg::CAP_DR;
      dpa_pkg::CAP_DR: next_tap_state = tms_s ? dpa_pkg::EX1_DR : dpa_pkg::SH_DR;
      dpa_pkg::SH_DR: next_tap_state = tms_s ? dpa_pkg::EX1_DR : dpa_pkg::SH_DR;
      dpa_pkg::EX1_DR: next_tap_state = tms_s ? dpa_pkg::UPD_DR : dpa_pkg::PAU_DR;
      dpa_pkg::PAU_DR: next_tap_state = tms_s ? dpa_pkg::EX2_DR : dpa_pkg::PAU_DR;
      dpa_pkg::EX2_DR: next_tap_state = tms_s ? dpa_pkg::UPD_DR : dpa_pkg::SH_DR;
      dpa_pkg::UPD_DR: next_tap_state = tms_s ? dpa_pkg::SEL_DR : dpa_pkg::RTI;
      dpa_pkg::SEL_IR: next_tap_state = tms_s ? dpa_pkg::TLR : dpa_pkg::CAP_IR;
      dpa_pkg::CAP_IR: next_tap_state = tms_s ? dpa_pkg::EX1_IR : dpa_pkg::SH_IR;
      dpa_pkg::SH_IR: next_tap_state = tms_s ? dpa_pkg::EX1_IR : dpa_pkg::SH_IR;
      dpa_pkg::EX1_IR: next_tap_state = tms_s ? dpa_pkg::UPD_IR : dpa_pkg::PAU_IR;
      dpa_pkg::PAU_IR: next_tap_state = tms_s ? dpa_pkg::EX2_IR : dpa_pkg::PAU_IR;
      dpa_pkg::EX2_IR: next_tap_state = tms_s ? dpa_pkg::UPD_IR : dpa_pkg::SH_IR;
      dpa_pkg::UPD_IR: next_tap_state = tms_s ? dpa_pkg::SEL_DR : dpa_pkg::RTI;
    endcase
  end

  // Test reset acts on level, with no test clock edge needed
  always_ff @(posedge core_clk) begin
    if (!nrst || !trst_s || !port_on) begin
      tap_state <= dpa_pkg::TLR;
    end else if (tck_rise) begin
      tap_state <= next_tap_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tap_state_out <= 4'h0;
    end else begin
      tap_state_out <= tap_state;
    end
  end

  // ----------------------------------------------------------------
  // Instruction and data registers
  // ----------------------------------------------------------------
  logic [dpa_pkg::IR_W-1:0] ir_shift;
  logic [dpa_pkg::IR_W-1:0] ir_active;
  logic [dpa_pkg::ID_W-1:0] dr_shift;

  always_ff @(posedge core_clk) begin
    if (!nrst || tap_state == dpa_pkg::TLR) begin
      ir_shift <= dpa_pkg::IR_CAPTURE;
      ir_active <= dpa_pkg::IR_RESET;
    end else if (tck_rise) begin
      unique case (tap_state)
        dpa_pkg::CAP_IR: ir_shift <= dpa_pkg::IR_CAPTURE;
        dpa_pkg::SH_IR: ir_shift <= {tdi_s, ir_shift[dpa_pkg::IR_W-1:1]};
        dpa_pkg::UPD_IR: ir_active <= ir_shift;
        default: ;
      endcase
    end
  end

  logic bypass_sel;
  assign bypass_sel = (ir_active != dpa_pkg::IR_IDCODE);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dr_shift <= '0;
    end else if (tck_rise) begin
      if (tap_state == dpa_pkg::CAP_DR) begin
        dr_shift <= bypass_sel ? '0 : dpa_pkg::ID_VALUE;
      end else if (tap_state == dpa_pkg::SH_DR) begin
        if (bypass_sel) begin
          dr_shift <= {{(dpa_pkg::ID_W-1){1'b0}}, tdi_s};
        end else begin
          dr_shift <= {tdi_s, dr_shift[dpa_pkg::ID_W-1:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Test data output, falling edge only
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tdo_pin <= 1'b0;
      tdo_pin_oe <= 1'b0;
    end else if (!port_on) begin
      tdo_pin_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_pin <= (tap_state == dpa_pkg::SH_IR) ? ir_shift[0] : dr_shift[0];
      tdo_pin_oe <= (tap_state == dpa_pkg::SH_IR) || (tap_state == dpa_pkg::SH_DR);
    end
  end

  // ----------------------------------------------------------------
  // Two-wire debug link on test clock and data pins
  // ----------------------------------------------------------------
  // Data in the two-wire mode is taken on the rising serial clock edge
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      link_rx_bit <= 1'b0;
      link_rx_strobe <= 1'b0;
      link_clk_fall <= 1'b0;
    end else begin
      link_rx_strobe <= link_on & tck_rise;
      link_clk_fall <= link_on & tck_fall;
      if (link_on && tck_rise) begin
        link_rx_bit <= tdi_s;
      end
    end
  end

  // Direction changes on falling serial clock edges; input after reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      debug_link_data_io_o <= 1'b0;
      debug_link_data_io_oe <= 1'b0;
    end else if (!link_on) begin
      debug_link_data_io_oe <= 1'b0;
    end else if (tck_fall) begin
      debug_link_data_io_o <= link_drive_bit;
      debug_link_data_io_oe <= link_drive_req;
    end
  end

  // ----------------------------------------------------------------
  // Trigger output pulse
  // ----------------------------------------------------------------
  logic [dpa_pkg::TRIG_CNT_W-1:0] trig_cnt;
  localparam logic [dpa_pkg::TRIG_CNT_W-1:0] TRIG_LEN =
    dpa_pkg::TRIG_CNT_W'(dpa_pkg::TRIG_PULSE_CYC);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      trig_cnt <= '0;
    end else if (port_on && trigger_event) begin
      trig_cnt <= TRIG_LEN;
    end else if (trig_cnt != '0) begin
      trig_cnt <= trig_cnt - 1'b1;
    end
  end

  // Drives high only during the pulse, otherwise released
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      trigger_pulse_out <= 1'b0;
      trigger_pulse_out_oe <= 1'b0;
    end else begin
      trigger_pulse_out <= (port_on && trigger_event) || (trig_cnt > 1);
      trigger_pulse_out_oe <= (port_on && trigger_event) || (trig_cnt > 1);
    end
  end

endmodule // dpa_debug_port

// File: dpa_pkg.sv
/*
  Shared constants and types of the debug port activation block.
  Assumes a single system clock and no software-visible registers.
*/
package dpa_pkg;

  // ----------------------------------------------------------------
  // Test access port controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } dpa_tap_e;

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET = 4'h1;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;

  // ----------------------------------------------------------------
  // Identification register; value is arbitrary, bit 0 must be one
  // ----------------------------------------------------------------
  localparam int ID_W = 32;
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0a5c_0001;

  // ----------------------------------------------------------------
  // Pin and timing constants
  // ----------------------------------------------------------------
  localparam logic PULLUP_LEVEL = 1'b1;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TRIG_PULSE_NS = 32;
  localparam int TRIG_PULSE_CYC =
    (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_CNT_W = 4;

endpackage

// File: dpa_debug_port_assertions.sv
/*
  Concurrent checks on the debug port front end.
  Sees only the top module ports; bound in below.
*/
`timescale 1ns/10ps
module dpa_debug_port_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Pins
  input wire logic tck_pin,
  input wire logic trst_n_pin,
  input wire logic trst_n_pin_drv,
  input wire logic tdo_pin,
  input wire logic debug_link_data_io_oe,
  input wire logic trigger_pulse_out,
  input wire logic trigger_pulse_out_oe,
  // User side and status
  input wire logic trigger_event,
  input wire logic link_rx_strobe,
  input wire logic test_port_enabled,
  input wire logic mode_valid,
  input wire logic [3:0] tap_state_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence s_trst_low;
    (trst_n_pin_drv && !trst_n_pin) [*5];
  endsequence
  sequence s_trig_req;
    trigger_event && mode_valid && test_port_enabled;
  endsequence
  sequence s_link_mode;
    mode_valid && !test_port_enabled;
  endsequence

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  AST_TRIG_START: assert property (s_trig_req |=> trigger_pulse_out && trigger_pulse_out_oe)
    else $error("trigger pulse did not start");
  AST_TRIG_LEN: assert property ($rose(trigger_pulse_out) |-> trigger_pulse_out [*4])
    else $error("trigger pulse too short");
  AST_TRIG_REL: assert property (!trigger_pulse_out |-> !trigger_pulse_out_oe)
    else $error("trigger pin driven while idle");
  AST_LINK_NO_TRIG: assert property (s_link_mode |-> !trigger_pulse_out_oe && tap_state_out == 4'h0)
    else $error("test port active in link mode");
  AST_TDI_INPUT: assert property (test_port_enabled |-> !debug_link_data_io_oe)
    else $error("data pin driven in test mode");
  AST_TRST: assert property (s_trst_low |=> tap_state_out == 4'h0)
    else $error("test reset did not reset controller");
  AST_TDO_FALL: assert property (mode_valid && $changed(tdo_pin) |-> !$past(tck_pin, 3))
    else $error("tdo changed away from falling clock");
  AST_MODE_HOLD: assert property (mode_valid |=> mode_valid && $stable(test_port_enabled))
    else $error("mode changed after latch");
  AST_LINK_IN: assert property ($rose(mode_valid) |-> !debug_link_data_io_oe)
    else $error("data pin not input after reset");
  AST_STROBE: assert property (link_rx_strobe |=> !link_rx_strobe)
    else $error("link strobe longer than one cycle");
endmodule // dpa_debug_port_assertions

bind dpa_debug_port dpa_debug_port_assertions i_chk (.core_clk(core_clk), .nrst(nrst), .tck_pin(tck_pin),
  .trst_n_pin(trst_n_pin), .trst_n_pin_drv(trst_n_pin_drv), .tdo_pin(tdo_pin),
  .debug_link_data_io_oe(debug_link_data_io_oe), .trigger_pulse_out(trigger_pulse_out),
  .trigger_pulse_out_oe(trigger_pulse_out_oe), .trigger_event(trigger_event), .link_rx_strobe(link_rx_strobe),
  .test_port_enabled(test_port_enabled), .mode_valid(mode_valid), .tap_state_out(tap_state_out));

// File: dpa_probe_model.sv
/*
  Behavioural debug probe that drives the test port pins.
  Assumes the bench paces it from the system clock falling edge.
*/
`timescale 1ns/10ps
module dpa_probe_model (
  // Pacing clock
  input wire logic core_clk,
  // Data from the port
  input wire logic tdo_pin,
  // Probe pins
  output logic tck_pin,
  output logic tck_pin_drv,
  output logic tms_pin,
  output logic tms_pin_drv,
  output logic tdi_pin,
  output logic trst_n_pin,
  output logic trst_n_pin_drv
);
  initial begin
    tck_pin = 1'b1;
    tck_pin_drv = 1'b0;
    tms_pin = 1'b1;
    tms_pin_drv = 1'b1;
    tdi_pin = 1'b0;
    trst_n_pin = 1'b1;
    trst_n_pin_drv = 1'b1;
  end

  // Clock level held through reset release
  task automatic park(input logic lvl, input logic drv);
    @(negedge core_clk);
    tck_pin = lvl;
    tck_pin_drv = drv;
  endtask

  // One clock period of 8 system cycles
  task automatic clk_bit(input logic tms_v, input logic tdi_v, output logic tdo_v);
    @(negedge core_clk);
    tck_pin = 1'b0;
    tms_pin = tms_v;
    tdi_pin = tdi_v;
    repeat (3) @(negedge core_clk);
    tck_pin = 1'b1;
    // Long high phase lets the state output settle before return
    repeat (4) @(negedge core_clk);
    tdo_v = tdo_pin;
    tdi_pin = ~tdi_v;
  endtask

  task automatic trst_pulse;
    @(negedge core_clk);
    trst_n_pin = 1'b0;
    repeat (6) @(negedge core_clk);
    trst_n_pin = 1'b1;
  endtask
endmodule // dpa_probe_model

// File: dpa_debug_port_tb.sv
/*
  Self-checking bench for the debug port front end.
  Assumes the probe model and the bound checker.
*/
`timescale 1ns/10ps
module dpa_debug_port_tb;
  logic core_clk, nrst, trigger_event, link_drive_req, link_drive_bit;
  logic tck_pin, tck_pin_drv, trst_n_pin, trst_n_pin_drv, tms_pin, tms_pin_drv, tdi_pin, data_wire;
  logic dio_o, dio_oe, tdo_pin, tdo_pin_oe, trig, trig_oe, link_rx_bit, link_rx_strobe, link_clk_fall;
  logic test_port_enabled, mode_valid;
  logic [3:0] tap_state_out;
  int error_cnt = 0;
  int checks = 0;
  int rx_cnt = 0;
  int fall_cnt = 0;

  // Count one-cycle link strobes away from the edge that launches them
  always @(negedge core_clk) begin
    if (link_rx_strobe === 1'b1) begin
      rx_cnt++;
    end
    if (link_clk_fall === 1'b1) begin
      fall_cnt++;
    end
  end

  // Two-way data pin level
  assign data_wire = dio_oe ? dio_o : tdi_pin;

  dpa_probe_model i_probe (.core_clk(core_clk), .tdo_pin(tdo_pin), .tck_pin(tck_pin), .tck_pin_drv(tck_pin_drv),
    .tms_pin(tms_pin), .tms_pin_drv(tms_pin_drv), .tdi_pin(tdi_pin), .trst_n_pin(trst_n_pin),
    .trst_n_pin_drv(trst_n_pin_drv));
  dpa_debug_port i_dut (.core_clk(core_clk), .nrst(nrst), .tck_pin(tck_pin), .tck_pin_drv(tck_pin_drv),
    .trst_n_pin(trst_n_pin), .trst_n_pin_drv(trst_n_pin_drv), .tms_pin(tms_pin), .tms_pin_drv(tms_pin_drv),
    .debug_link_data_io_i(data_wire), .debug_link_data_io_o(dio_o), .debug_link_data_io_oe(dio_oe),
    .tdo_pin(tdo_pin), .tdo_pin_oe(tdo_pin_oe), .trigger_pulse_out(trig), .trigger_pulse_out_oe(trig_oe),
    .trigger_event(trigger_event), .link_drive_req(link_drive_req), .link_drive_bit(link_drive_bit),
    .link_rx_bit(link_rx_bit), .link_rx_strobe(link_rx_strobe), .link_clk_fall(link_clk_fall),
    .test_port_enabled(test_port_enabled), .mode_valid(mode_valid), .tap_state_out(tap_state_out));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reset_dut(input logic lvl, input logic drv);
    i_probe.park(lvl, drv);
    nrst = 1'b0;
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_idcode;
    logic t;
    logic [31:0] id;
    reset_dut(1'b0, 1'b1);
    chk("port_en", test_port_enabled, 1);
    chk("mode_valid", mode_valid, 1);
    i_probe.clk_bit(1'b0, 1'b0, t);
    chk("state_rti", tap_state_out, dpa_pkg::RTI);
    i_probe.clk_bit(1'b1, 1'b0, t);
    i_probe.clk_bit(1'b0, 1'b0, t);
    i_probe.clk_bit(1'b0, 1'b0, t);
    chk("state_shift", tap_state_out, dpa_pkg::SH_DR);
    for (int k = 0; k < 32; k++) begin
      i_probe.clk_bit(k == 31, k[0], t);
      id[k] = t;
    end
    chk("idcode", id, dpa_pkg::ID_VALUE);
    chk("tdo_oe", tdo_pin_oe, 1);
    i_probe.trst_pulse();
    chk("state_trst", tap_state_out, dpa_pkg::TLR);
    $display("test idcode done");
  endtask

  task automatic t_trigger;
    @(negedge core_clk);
    trigger_event = 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(negedge core_clk);
      trigger_event = 1'b0;
      chk("trigger", {trig, trig_oe}, (i < 4) ? 2'b11 : 2'b00);
    end
    $display("test trigger done");
  endtask

  task automatic t_link;
    logic t;
    reset_dut(1'b0, 1'b0);
    chk("port_en", test_port_enabled, 0);
    chk("data_oe", dio_oe, 0);
    i_probe.park(1'b1, 1'b1);
    i_probe.clk_bit(1'b0, 1'b1, t);
    chk("rx_one", link_rx_bit, 1);
    i_probe.clk_bit(1'b0, 1'b0, t);
    chk("rx_zero", link_rx_bit, 0);
    link_drive_req = 1'b1;
    link_drive_bit = 1'b1;
    i_probe.clk_bit(1'b0, 1'b0, t);
    chk("drive", {dio_oe, dio_o, data_wire}, 3'b111);
    chk("rx_strobes", rx_cnt, 3);
    chk("clk_falls", fall_cnt, 3);
    link_drive_req = 1'b0;
    trigger_event = 1'b1;
    @(negedge core_clk);
    trigger_event = 1'b0;
    @(negedge core_clk);
    chk("trig_off", trig_oe, 0);
    $display("test link done");
  endtask

  initial begin
    nrst = 1'b0;
    trigger_event = 1'b0;
    link_drive_req = 1'b0;
    link_drive_bit = 1'b0;
    t_idcode();
    t_trigger();
    t_link();
    finish_test();
  end

  // Hang guard well beyond the expected run of about 350 cycles
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule // dpa_debug_port_tb
